// ===== core/ptfe_engine.v
// Precision-time frame engine with its output FIFO
`default_nettype none
`include "ptfe_regs.vh"

// Output FIFO, valid/ready on both sides
module ptfe_fifo #(
   parameter WIDTH = `PTFE_FIFO_WIDTH,
   parameter DEPTH = `PTFE_FIFO_DEPTH
) (
   input  wire             clk_sys,
   input  wire             rst_n,
   input  wire             wrValid,
   output wire             wrReady,
   input  wire [WIDTH-1:0] wrData,
   output wire             rdValid,
   input  wire             rdReady,
   output wire [WIDTH-1:0] rdData
);
   localparam AW = $clog2(DEPTH);
   reg [WIDTH-1:0] mem [0:DEPTH-1];   // Storage words
   reg [AW-1:0]    wrPtr_reg;         // Write index
   reg [AW-1:0]    rdPtr_reg;         // Read index
   reg [AW:0]      count_reg;         // Words held
   wire            doWr;
   wire            doRd;

   assign wrReady = (count_reg != DEPTH[AW:0]);
   assign rdValid = (count_reg != {(AW+1){1'b0}});
   assign rdData  = mem[rdPtr_reg];
   assign doWr    = wrValid && wrReady;
   assign doRd    = rdValid && rdReady;

   // Storage write
   always @(posedge clk_sys)
   begin
      if (doWr)
         mem[wrPtr_reg] <= wrData;
   end

   // Pointers and fill count
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         wrPtr_reg <= {AW{1'b0}};
         rdPtr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (doWr)
            wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
         if (doRd)
            rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
         if (doWr && !doRd)
            count_reg <= count_reg + 1'b1;
         else if (doRd && !doWr)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule // ptfe_fifo

// Summary of operation
// - One engine per port and direction
// - Time taken from shared local time counter
// - Standalone or header mode selected by input
// - Standalone mode stamps only express unfragmented frames
// - Receive stamps queued for time-protocol frames
// - Receive writes arrival subseconds into reserved field
// - IPv4 UDP checksum checked, bad forces FCS
// - IPv6 UDP checksum checked, pad updated
// - FCS recomputed, bad input keeps bad FCS
// - Transmit departure stamps queued
// - Transmit extracts arrival from reserved field
// - Correction gains departure plus delay minus arrival
// - Transmit fixes FCS, IPv6 pad, clears IPv4
// - Header mode stamps every frame
// - Header mode replaces preamble with header
// - Header packet type is zero
// - Header subport number is port number
// - Extension type follows preemption enable
// - Extension top byte carries preemption state
// - Extension low word holds arrival subseconds
// - Header ends with check byte
module ptfe_engine (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        headerMode,
   input  wire        isTransmit,
   input  wire [1:0]  portNumber,
   input  wire        preemptEnable,
   input  wire [7:0]  preemptState,
   input  wire [15:0] txDelayNs,
   input  wire        udp4Clear,
   input  wire        udp6ZeroCheck,
   input  wire        udp6PadUpdate,
   input  wire [29:0] localSubsec,
   input  wire [7:0]  inData,
   input  wire        inValid,
   input  wire        inLast,
   output wire        inReady,
   output wire [7:0]  outData,
   output wire        outValid,
   output wire        outLast,
   input  wire        outReady,
   output wire        tsqValid,
   output wire [29:0] tsqTime,
   output wire [29:0] tsqArrival
);
   localparam S_PRE   = 2'h0;   // Idle or in preamble
   localparam S_HDR   = 2'h1;   // Sending inserted header
   localparam S_BODY  = 2'h2;   // Frame body through delay line
   localparam S_FLUSH = 2'h3;   // Draining delay line
   localparam C_NONE  = 2'h0;
   localparam C_L2    = 2'h1;
   localparam C_V4    = 2'h2;
   localparam C_V6    = 2'h3;

   // One CRC-32 byte step
   function [31:0] crc32Byte;
      input [31:0] c;
      input [7:0]  d;
      integer      i;
      reg   [31:0] r;
      begin
         r = c ^ {24'h000000, d};
         for (i = 0; i < 8; i = i + 1)
            r = r[0] ? ((r >> 1) ^ `PTFE_CRC32_POLY) : (r >> 1);
         crc32Byte = r;
      end
   endfunction

   // Ones-complement add
   function [15:0] onesAdd;
      input [15:0] a;
      input [15:0] b;
      reg   [16:0] s;
      begin
         s       = {1'b0, a} + {1'b0, b};
         onesAdd = s[15:0] + {15'h0000, s[16]};
      end
   endfunction

   // Byte placed in its checksum word lane
   function [15:0] laneWord;
      input [7:0]  b;
      input [15:0] pos;
      begin
         laneWord = pos[0] ? {8'h00, b} : {b, 8'h00};
      end
   endfunction

   // Header check byte, MSB first
   function [7:0] crc8Hdr;
      input [47:0] d;
      integer      i;
      reg   [7:0]  r;
      begin
         r = `PTFE_CRC8_INIT;
         for (i = 47; i >= 0; i = i - 1)
            r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? `PTFE_CRC8_POLY : 8'h00);
         crc8Hdr = r;
      end
   endfunction

   reg  [1:0]  state_reg;        // Engine state
   reg         inFrame_reg;      // First byte of frame taken
   reg  [29:0] stamp_reg;        // Captured frame time
   reg  [29:0] arr_reg;          // Extracted arrival time
   reg         express_reg;      // Express start delimiter seen
   reg  [1:0]  cls_reg;          // Frame class
   reg         ptp_reg;          // Time-protocol frame
   reg  [7:0]  hiByte_reg;       // High byte of a 16-bit field
   reg  [15:0] inPos_reg;        // Input body position
   reg  [15:0] outPos_reg;       // Output body position
   reg  [15:0] len_reg;          // Body length incl. FCS
   reg  [3:0]  fill_reg;         // Delay line fill
   reg  [7:0]  dly [0:11];       // Delay line, oldest at 0
   reg  [31:0] crcIn_reg;        // Incoming FCS check
   reg  [31:0] crcOut_reg;       // Outgoing FCS
   reg  [15:0] sum_reg;          // UDP checksum sum
   reg  [15:0] adj_reg;          // Checksum change from edits
   reg         ckNz_reg;         // Checksum field non-zero
   reg  [63:0] cfOrig_reg;       // Original correction
   reg  [7:0]  padLo_reg;        // Low pad byte to send
   reg  [2:0]  hdrIdx_reg;       // Header byte index
   reg         tsqValid_reg;     // Queue push pulse
   reg  [29:0] tsqTime_reg;      // Queued frame time
   reg  [29:0] tsqArrival_reg;   // Queued arrival time
   reg         push;             // Byte to FIFO
   reg  [7:0]  pushByte;         // Byte value
   reg         pushLast;         // Last byte of frame
   reg  [7:0]  modByte;          // Body byte after edits
   wire        fifoInReady;
   wire        accept;
   wire        emitGo;
   wire        bodyEmit;
   wire        isV4;
   wire        isV6;
   wire        touch;
   wire        doPtp;
   wire [15:0] ptpOff;
   wire [15:0] rel;
   wire [15:0] relIn;
   wire [15:0] fcsStart;
   wire        isFcs;
   wire [1:0]  fcsIdx;
   wire [30:0] deltaNs;
   wire [31:0] resNs;
   wire [63:0] cfNew;
   wire [63:0] cfSh;
   wire [31:0] rsvSh;
   wire [31:0] fcsSh;
   wire        inRsv;
   wire        inCf;
   wire        modFld;
   wire        ckHit;
   wire        lenHit;
   wire        sumOn;
   wire        padHi;
   wire        padLo;
   wire [15:0] padNew;
   wire        udpBad;
   wire        frameBad;
   wire [47:0] hdrVec;
   wire [47:0] hdrSh;
   wire [3:0]  dlyWr;

   assign accept   = inValid && inReady;
   assign inReady  = fifoInReady && (state_reg == S_PRE || state_reg == S_BODY);
   assign emitGo   = push && fifoInReady;
   assign bodyEmit = emitGo && state_reg[1];
   assign isV4     = (cls_reg == C_V4);
   assign isV6     = (cls_reg == C_V6);
   assign touch    = express_reg && !headerMode;
   assign doPtp    = touch && ptp_reg;
   assign ptpOff   = isV6 ? `PTFE_OFF_PTPV6 : (isV4 ? `PTFE_OFF_PTPV4 : `PTFE_OFF_PTPL2);
   assign rel      = outPos_reg - ptpOff;
   assign relIn    = inPos_reg - ptpOff;
   assign fcsStart = len_reg - 16'h0004;
   assign isFcs    = (state_reg == S_FLUSH) && touch && (outPos_reg >= fcsStart);
   assign fcsIdx   = outPos_reg[1:0] - fcsStart[1:0];

   // Correction update, wrapping the subsecond difference
   assign deltaNs = (stamp_reg >= arr_reg) ? ({1'b0, stamp_reg} - {1'b0, arr_reg})
                  : ({1'b0, stamp_reg} + `PTFE_NS_PER_SEC - {1'b0, arr_reg});
   assign resNs   = {1'b0, deltaNs} + {16'h0000, txDelayNs};
   assign cfNew   = cfOrig_reg + {16'h0000, resNs, 16'h0000};
   assign cfSh    = cfNew >> {~rel[2:0], 3'h0};
   assign rsvSh   = {2'b00, stamp_reg} >> {~rel[1:0], 3'h0};
   assign inRsv   = doPtp && !isTransmit && rel >= `PTFE_PTP_RSV && rel < `PTFE_PTP_RSV_END;
   assign inCf    = doPtp && isTransmit && rel >= `PTFE_PTP_CF && rel < `PTFE_PTP_CF_END;
   assign modFld  = inRsv || inCf;

   // UDP field positions
   assign ckHit  = touch && cls_reg[1]
                && outPos_reg[15:1] == (isV6 ? `PTFE_OFF_V6CK : `PTFE_OFF_V4CK) >> 1;
   assign lenHit = outPos_reg[15:1] == (isV6 ? `PTFE_OFF_V6ULEN : `PTFE_OFF_V4ULEN) >> 1;
   assign sumOn  = touch && cls_reg[1] && !isFcs
                && outPos_reg >= (isV6 ? `PTFE_OFF_V6SUM : `PTFE_OFF_V4SUM);
   assign padHi  = doPtp && isV6 && udp6PadUpdate && (state_reg == S_FLUSH)
                && outPos_reg == len_reg - 16'h0006;
   assign padLo  = doPtp && isV6 && udp6PadUpdate && (state_reg == S_FLUSH)
                && outPos_reg == len_reg - 16'h0005;
   assign padNew = onesAdd({dly[0], dly[1]}, adj_reg);

   // Receive verdict on the UDP checksum
   assign udpBad = !isTransmit && doPtp && cls_reg[1]
                && ((sum_reg != 16'hFFFF && !(isV4 && !ckNz_reg))
                 || (isV6 && udp6ZeroCheck && !ckNz_reg));
   assign frameBad = (crcIn_reg != `PTFE_CRC32_RESID) || udpBad;
   assign fcsSh    = (frameBad ? crcOut_reg : ~crcOut_reg) >> {fcsIdx, 3'h0};

   // Inserted header fields
   assign hdrVec = {`PTFE_PKT_TYPE, 2'b00, portNumber,
                    preemptEnable ? `PTFE_EXT_PRE : `PTFE_EXT_NOPRE,
                    preemptState,
                    2'b00, stamp_reg};
   assign hdrSh  = hdrVec >> {3'h5 - hdrIdx_reg, 3'h0};
   assign dlyWr  = (fill_reg == `PTFE_DLY_LEN) ? 4'hB : fill_reg;

   // Body byte edits, checked in priority order
   always @*
   begin
      modByte = dly[0];
      if (isFcs)
         modByte = fcsSh[7:0];                 // Fresh FCS
      else if (inRsv)
         modByte = rsvSh[7:0];                 // Arrival into reserved field
      else if (inCf)
         modByte = cfSh[7:0];                  // New correction
      else if (ckHit && isV4 && (!isTransmit || udp4Clear))
         modByte = 8'h00;                      // Cleared checksum
      else if (padHi)
         modByte = padNew[15:8];               // Pad compensation
      else if (padLo)
         modByte = padLo_reg;
   end

   // What goes to the FIFO this cycle
   always @*
   begin
      push     = 1'b0;
      pushByte = modByte;
      pushLast = 1'b0;
      case (state_reg)
         S_PRE:
         begin
            push     = accept && !headerMode;   // Preamble passes in standalone
            pushByte = inData;
         end
         S_HDR:
         begin
            push     = 1'b1;                    // Header replaces preamble
            pushByte = (hdrIdx_reg == `PTFE_HDR_LAST) ? crc8Hdr(hdrVec) : hdrSh[7:0];
         end
         S_BODY:
            push = accept && (fill_reg == `PTFE_DLY_LEN);
         S_FLUSH:
         begin
            push     = (fill_reg != 4'h0);
            pushLast = (fill_reg == 4'h1);
         end
         default:
            push = 1'b0;
      endcase
   end

   // Delay line shift and fill
   always @(posedge clk_sys)
   begin : dlyShift
      integer i;
      if (bodyEmit)
         for (i = 0; i < 11; i = i + 1)
            dly[i] <= dly[i + 1];
      if (accept && state_reg == S_BODY)
         dly[dlyWr] <= inData;
   end

   // Frame sequencing, parsing and checks
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_reg      <= S_PRE;
         inFrame_reg    <= 1'b0;
         stamp_reg      <= 30'h00000000;
         arr_reg        <= 30'h00000000;
         express_reg    <= 1'b0;
         cls_reg        <= C_NONE;
         ptp_reg        <= 1'b0;
         hiByte_reg     <= 8'h00;
         inPos_reg      <= 16'h0000;
         outPos_reg     <= 16'h0000;
         len_reg        <= 16'h0000;
         fill_reg       <= 4'h0;
         crcIn_reg      <= `PTFE_CRC32_INIT;
         crcOut_reg     <= `PTFE_CRC32_INIT;
         sum_reg        <= 16'h0000;
         adj_reg        <= 16'h0000;
         ckNz_reg       <= 1'b0;
         cfOrig_reg     <= 64'h0000000000000000;
         padLo_reg      <= 8'h00;
         hdrIdx_reg     <= 3'h0;
         tsqValid_reg   <= 1'b0;
         tsqTime_reg    <= 30'h00000000;
         tsqArrival_reg <= 30'h00000000;
      end
      else
      begin
         tsqValid_reg <= 1'b0;
         case (state_reg)
            S_PRE:
               if (accept)
               begin
                  if (!inFrame_reg)
                  begin
                     stamp_reg   <= localSubsec;     // Stamp at first byte
                     inFrame_reg <= 1'b1;
                  end
                  if (inData != `PTFE_PREAMBLE)
                  begin
                     express_reg <= (inData == `PTFE_SFD_EXPRESS);
                     state_reg   <= headerMode ? S_HDR : S_BODY;
                     inPos_reg   <= 16'h0000;
                     outPos_reg  <= 16'h0000;
                     fill_reg    <= 4'h0;
                     cls_reg     <= C_NONE;
                     ptp_reg     <= 1'b0;
                     crcIn_reg   <= `PTFE_CRC32_INIT;
                     crcOut_reg  <= `PTFE_CRC32_INIT;
                     sum_reg     <= {8'h00, `PTFE_IP_UDP};
                     adj_reg     <= 16'h0000;
                     ckNz_reg    <= 1'b0;
                     hdrIdx_reg  <= 3'h0;
                  end
               end
            S_HDR:
               if (fifoInReady)
               begin
                  hdrIdx_reg <= hdrIdx_reg + 3'h1;
                  if (hdrIdx_reg == `PTFE_HDR_LAST)
                     state_reg <= S_BODY;
               end
            S_BODY:
               if (accept)
               begin
                  crcIn_reg <= crc32Byte(crcIn_reg, inData);
                  inPos_reg <= inPos_reg + 16'h0001;
                  if (fill_reg != `PTFE_DLY_LEN)
                     fill_reg <= fill_reg + 4'h1;
                  // Classification on the incoming side
                  if (inPos_reg == `PTFE_OFF_ETYPE)
                     hiByte_reg <= inData;
                  if (inPos_reg == `PTFE_OFF_ETYPE + 16'h0001)
                  begin
                     ptp_reg <= ({hiByte_reg, inData} == `PTFE_ET_PTP);
                     if ({hiByte_reg, inData} == `PTFE_ET_PTP)
                        cls_reg <= C_L2;
                     else if ({hiByte_reg, inData} == `PTFE_ET_IPV4)
                        cls_reg <= C_V4;
                     else if ({hiByte_reg, inData} == `PTFE_ET_IPV6)
                        cls_reg <= C_V6;
                  end
                  if (isV4 && inPos_reg == `PTFE_OFF_V4VER && inData != `PTFE_V4_VERIHL)
                     cls_reg <= C_NONE;              // Options not handled
                  if (cls_reg[1] && inData != `PTFE_IP_UDP
                      && inPos_reg == (isV6 ? `PTFE_OFF_V6NXT : `PTFE_OFF_V4PROTO))
                     cls_reg <= C_NONE;
                  if (cls_reg[1] && inPos_reg == (isV6 ? `PTFE_OFF_V6DPORT : `PTFE_OFF_V4DPORT))
                     hiByte_reg <= inData;
                  if (cls_reg[1] && inPos_reg == (isV6 ? `PTFE_OFF_V6DPORT : `PTFE_OFF_V4DPORT)
                      + 16'h0001 && ({hiByte_reg, inData} == `PTFE_PORT_EVT
                      || {hiByte_reg, inData} == `PTFE_PORT_GEN))
                     ptp_reg <= 1'b1;
                  // Message fields captured ahead of their output
                  if (ptp_reg && relIn >= `PTFE_PTP_CF && relIn < `PTFE_PTP_CF_END)
                     cfOrig_reg <= {cfOrig_reg[55:0], inData};
                  if (ptp_reg && relIn >= `PTFE_PTP_RSV && relIn < `PTFE_PTP_RSV_END)
                     arr_reg <= {arr_reg[21:0], inData};   // Low 30 bits kept
                  if (inLast)
                  begin
                     state_reg <= S_FLUSH;
                     len_reg   <= inPos_reg + 16'h0001;
                  end
               end
            S_FLUSH:
               if (fill_reg == 4'h0)
               begin
                  state_reg   <= S_PRE;              // Empty body
                  inFrame_reg <= 1'b0;
               end
               else if (fifoInReady)
               begin
                  fill_reg <= fill_reg - 4'h1;
                  if (fill_reg == 4'h1)
                  begin
                     state_reg      <= S_PRE;
                     inFrame_reg    <= 1'b0;
                     tsqValid_reg   <= doPtp;        // Queue entry
                     tsqTime_reg    <= stamp_reg;
                     tsqArrival_reg <= isTransmit ? arr_reg : stamp_reg;
                  end
               end
            default:
               state_reg <= S_PRE;
         endcase
         // Outgoing-side bookkeeping per body byte
         if (bodyEmit)
         begin
            outPos_reg <= outPos_reg + 16'h0001;
            if (!isFcs)
               crcOut_reg <= crc32Byte(crcOut_reg, modByte);
            if (sumOn)
               sum_reg <= onesAdd(onesAdd(sum_reg, laneWord(dly[0], outPos_reg)),
                                  lenHit ? laneWord(dly[0], outPos_reg) : 16'h0000);
            if (ckHit && dly[0] != 8'h00)
               ckNz_reg <= 1'b1;
            if (modFld)
               adj_reg <= onesAdd(onesAdd(adj_reg, laneWord(dly[0], outPos_reg)),
                                  ~laneWord(modByte, outPos_reg));
            if (padHi)
               padLo_reg <= padNew[7:0];
         end
      end
   end

   // Output buffer toward the far side
   ptfe_fifo #(
      .WIDTH (`PTFE_FIFO_WIDTH),
      .DEPTH (`PTFE_FIFO_DEPTH)
   ) outFifo (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wrValid (push),
      .wrReady (fifoInReady),
      .wrData  ({pushLast, pushByte}),
      .rdValid (outValid),
      .rdReady (outReady),
      .rdData  ({outLast, outData})
   );

   // One instance serves one direction of one port
   assign tsqValid   = tsqValid_reg;
   assign tsqTime    = tsqTime_reg;
   assign tsqArrival = tsqArrival_reg;
endmodule // ptfe_engine
`default_nettype wire

// ===== core/ptfe_regs.vh
// Constants for the precision-time frame engine
`ifndef PTFE_REGS_VH
`define PTFE_REGS_VH
// Line coding
`define PTFE_PREAMBLE     8'h55
`define PTFE_SFD_EXPRESS  8'hD5
// Engine structure
`define PTFE_DLY_LEN      4'hC
`define PTFE_HDR_LAST     3'h6
`define PTFE_FIFO_WIDTH   9
`define PTFE_FIFO_DEPTH   8
// Frame check sequence, reflected form
`define PTFE_CRC32_POLY   32'hEDB88320
`define PTFE_CRC32_INIT   32'hFFFFFFFF
`define PTFE_CRC32_RESID  32'hDEBB20E3
// Header check byte
`define PTFE_CRC8_POLY    8'h07
`define PTFE_CRC8_INIT    8'h00
// Header field values
`define PTFE_PKT_TYPE     2'h0
`define PTFE_EXT_NOPRE    2'h1
`define PTFE_EXT_PRE      2'h2
// Classification values
`define PTFE_ET_PTP       16'h88F7
`define PTFE_ET_IPV4      16'h0800
`define PTFE_ET_IPV6      16'h86DD
`define PTFE_IP_UDP       8'h11
`define PTFE_V4_VERIHL    8'h45
`define PTFE_PORT_EVT     16'h013F
`define PTFE_PORT_GEN     16'h0140
// Byte offsets from the first byte after the start delimiter
`define PTFE_OFF_ETYPE    16'h000C
`define PTFE_OFF_V4VER    16'h000E
`define PTFE_OFF_V4PROTO  16'h0017
`define PTFE_OFF_V4SUM    16'h001A
`define PTFE_OFF_V4DPORT  16'h0024
`define PTFE_OFF_V4ULEN   16'h0026
`define PTFE_OFF_V4CK     16'h0028
`define PTFE_OFF_V6NXT    16'h0014
`define PTFE_OFF_V6SUM    16'h0016
`define PTFE_OFF_V6DPORT  16'h0038
`define PTFE_OFF_V6ULEN   16'h003A
`define PTFE_OFF_V6CK     16'h003C
`define PTFE_OFF_PTPL2    16'h000E
`define PTFE_OFF_PTPV4    16'h002A
`define PTFE_OFF_PTPV6    16'h003E
// Offsets inside the time-protocol message header
`define PTFE_PTP_CF       16'h0008
`define PTFE_PTP_CF_END   16'h0010
`define PTFE_PTP_RSV      16'h0010
`define PTFE_PTP_RSV_END  16'h0014
// Time
`define PTFE_NS_PER_SEC   31'h3B9ACA00
`endif

// ===== sim/ptfe_sink.sv
// Far-side stream sink, prompt or stalling
`default_nettype none
module ptfe_sink (
   input  wire logic clk_sys,
   input  wire logic slow,
   output var  logic outReady = 1'h1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_reg = 2'h0; // Stall phase
   // Ready one cycle in four while slow
   always @(posedge clk_sys)
   begin
      phase_reg <= phase_reg + 2'h1;
      outReady <= !slow || phase_reg == 2'h3;
   end
endmodule // ptfe_sink
`default_nettype wire

// ===== sim/ptfe_engine_props.sv
// Checker on the frame engine ports
`default_nettype none
module ptfe_engine_props (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        headerMode,
   input wire logic        isTransmit,
   input wire logic [1:0]  portNumber,
   input wire logic        preemptEnable,
   input wire logic [7:0]  preemptState,
   input wire logic [7:0]  outData,
   input wire logic        outValid,
   input wire logic        outLast,
   input wire logic        outReady,
   input wire logic        tsqValid,
   input wire logic [29:0] tsqTime,
   input wire logic [29:0] tsqArrival
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [3:0] pos_reg;                 // Bytes taken in this frame
   wire        take = outValid && outReady; // Output handshake
   // Position of the output byte within its frame
   always @(posedge clk_sys)
      if (!rst_n || (take && outLast))
         pos_reg <= 4'h0;
      else if (take && pos_reg != 4'hF)
         pos_reg <= pos_reg + 4'h1;
   sequence hdrAt(n);
      headerMode && outValid && pos_reg == n;
   endsequence
   stall_hold_a: assert property (outValid && !outReady |=> outValid && $stable(outData))
      else $error("output moved while stalled");
   hdr_type_a: assert property (hdrAt(0) |-> outData == {4'h0, portNumber,
      preemptEnable ? 2'h2 : 2'h1}) else $error("bad first header byte");
   hdr_state_a: assert property (hdrAt(1) |-> outData == preemptState)
      else $error("bad preemption byte");
   hdr_stamp_a: assert property (hdrAt(2) |-> outData[7:6] == 2'h0)
      else $error("stamp top bits set");
   hdr_nolast_a: assert property (headerMode && outValid && pos_reg < 4'h7 |-> !outLast)
      else $error("frame end inside header");
   tsq_pulse_a: assert property (tsqValid |=> !tsqValid) else $error("long stamp pulse");
   rx_same_a: assert property (tsqValid && !isTransmit |-> tsqTime == tsqArrival)
      else $error("receive stamps differ");
   hdr_nostamp_a: assert property (headerMode && $past(headerMode) |-> !tsqValid)
      else $error("stamp pulse in header mode");
endmodule // ptfe_engine_props
bind ptfe_engine ptfe_engine_props props_u (.clk_sys, .rst_n, .headerMode, .isTransmit,
   .portNumber, .preemptEnable, .preemptState, .outData, .outValid, .outLast, .outReady,
   .tsqValid, .tsqTime, .tsqArrival);
`default_nettype wire

// ===== sim/ptp_timestamp_frame_engine_bench.sv
// Self-checking bench for the frame engine
`default_nettype none
module ptp_timestamp_frame_engine_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'h0, rst_n = 1'h0, headerMode = 1'h0, preemptEnable = 1'h0, slow = 1'h0;
   logic inValid = 1'h0, inLast = 1'h0, fin, inReady, outValid, outLast, outReady, tsqValid;
   logic [1:0] portNumber = 2'h0;
   logic [7:0] preemptState = 8'h00, inData = 8'h00, outData, fr[$], ex[$], got[$];
   logic [29:0] localSubsec = 30'h0, tsqTime, tsqArrival;
   logic [47:0] w;
   int err_count = 0, check_count = 0, ts = 0;
   // Rows: preamble count, port, preemption, state, subseconds, first header byte
   logic [51:0] rows [4] = '{{3'h7, 2'h0, 1'h0, 8'h00, 30'h00000000, 8'h01},
      {3'h3, 2'h1, 1'h1, 8'hA5, 30'h3FFFFFFF, 8'h06},
      {3'h3, 2'h2, 1'h0, 8'h5A, 30'h15555555, 8'h09},
      {3'h7, 2'h3, 1'h1, 8'hFF, 30'h2AAAAAAA, 8'h0E}};
   always #5 clk_sys = ~clk_sys;
   ptfe_engine dut_u (.clk_sys, .rst_n, .headerMode, .isTransmit(1'h0), .portNumber,
      .preemptEnable, .preemptState, .txDelayNs(16'h0000), .udp4Clear(slow),
      .udp6ZeroCheck(1'h0), .udp6PadUpdate(1'h0), .localSubsec, .inData, .inValid, .inLast,
      .inReady, .outData, .outValid, .outLast, .outReady, .tsqValid, .tsqTime, .tsqArrival);
   ptfe_sink sink_u (.clk_sys, .slow, .outReady);
   // Collects output bytes, frame ends and stamp pulses
   always @(posedge clk_sys)
   begin
      if ((outValid & outReady) === 1'h1)
         got.push_back(outData);
      fin = fin || (outValid & outReady & outLast) === 1'h1;
      ts = ts + (tsqValid === 1'h1);
   end
   task automatic chk(input logic [63:0] a, e);
      check_count++;
      if (a !== e)
      begin
         err_count++;
         $display("mismatch %0t got %h want %h", $time, a, e);
      end
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [31:0] fcs(input logic [7:0] q[$]);
      logic [31:0] c = 32'hFFFFFFFF;
      foreach (q[i])
         for (int b = 0; b < 8; b++)
            c = i < 8 ? c : (c >> 1) ^ (c[0] ^ q[i][b] ? 32'hEDB88320 : 32'h0);
      return ~c;
   endfunction
   // Offers the frame, waits for its end, compares; a bad check only has to differ
   task automatic send(input logic bad);
      int i = 0, n = 0, m = ex.size() - (bad ? 4 : 0);
      logic r;
      fin = 1'h0;
      got = {};
      while ((i < fr.size() || !fin) && n++ < 4000)
      begin
         inValid <= i < fr.size();
         inData <= i < fr.size() ? fr[i] : 8'h00;
         inLast <= i == fr.size() - 1;
         @(negedge clk_sys) r = inReady;
         @(posedge clk_sys);
         i = i + (r === 1'h1 && i < fr.size());
      end
      chk(30'(n < 4000), 30'h1);
      if (n >= 4000)
         tally_and_finish();
      repeat (3) @(posedge clk_sys);
      chk(30'(got.size()), 30'(ex.size()));
      for (int k = 0; k < m && k < got.size(); k++)
         chk(got[k], ex[k]);
      if (bad && got.size() == ex.size())
         chk(30'({got[m + 3], got[m + 2], got[m + 1], got[m]} == fcs(ex[0:m - 1])), 30'h0);
   endtask
   initial
   begin
      repeat (16) @(posedge clk_sys);
      chk({outValid, inReady, tsqValid, tsqTime}, 33'h080000000);
      rst_n <= 1'h1;
      headerMode <= 1'h1;
      foreach (rows[r])
      begin
         {portNumber, preemptEnable, preemptState, localSubsec} <= rows[r][48:8];
         slow <= r[0];
         w = {rows[r][7:0], rows[r][45:38], 2'h0, rows[r][37:8]};
         fr = {};
         repeat (rows[r][51:49]) fr.push_back(8'h55);
         for (int k = 0; k < 21; k++)
            fr.push_back(k ? 8'(k * 13) : 8'hD5);
         ex = {w[47:40], w[39:32], w[31:24], w[23:16], w[15:8], w[7:0], 8'h00};
         for (int b = 47; b >= 0; b--)
            ex[6] = {ex[6][6:0], 1'h0} ^ (ex[6][7] ^ w[b] ? 8'h07 : 8'h00);
         ex = {ex, fr[rows[r][51:49] + 1:$]};
         send(1'h0);
      end
      chk(30'(ts), 30'h0);
      headerMode <= 1'h0;
      for (int bad = 0; bad < 2; bad++)
      begin
         ts = 0;
         fr = {8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'hD5};
         for (int k = 0; k < 60; k++)
            fr.push_back(k == 12 ? 8'h88 : k == 13 ? 8'hF7 : k == 15 ? 8'h02 : 8'(k % 30));
         ex = fr;
         {ex[38], ex[39], ex[40], ex[41]} = {2'h0, localSubsec};
         for (int b = 0; b < 4; b++)
         begin
            fr.push_back(8'((fcs(fr[0:67]) ^ {32{bad[0]}}) >> 8 * b));
            ex.push_back(8'(fcs(ex[0:67]) >> 8 * b));
         end
         send(bad[0]);
         chk({30'(ts), tsqTime}, {30'h1, localSubsec});
      end
      chk(tsqArrival, localSubsec);
      tally_and_finish();
   end
endmodule // ptp_timestamp_frame_engine_bench
`default_nettype wire
